// ---- src/rble_pkg.sv ----
package rble_pkg;

    // Encoding control register width and field positions.
    localparam int CTRL_W         = 4;
    localparam int CTRL_INV_BIT   = 0;
    localparam int CTRL_DIFF_BIT  = 1;
    localparam int CTRL_MANCH_BIT = 2;
    localparam int CTRL_SHAPE_BIT = 3;

    // Reset value of the control register: every transform off.
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // Transmit buffer geometry.
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 16;

    // Self-synchronizing scrambler: x^17 + x^12 + 1.
    localparam int SCR_LEN = 17;
    localparam int SCR_TAP = 12;

endpackage

// ---- src/rble_encoder.sv ----
// Contract
// - Encoder sits between framer and modem
// - Inversion complements bits both directions
// - Differential transmit: zero holds, one toggles
// - Differential receive compares level with previous
// - Manchester makes two half-bit symbols per bit
// - Shaping maps one bit to one bit
// - Self-synchronizing scrambler and matching descrambler
// - Shaping breaks DC, runs and periodic data, except zeros fed into an all-zero history, as after reset
`timescale 1ns/1ns

// Synchronous FIFO with a registered ready flag and a count-based valid flag.
module rble_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             srst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];     // Storage array.
    logic [AW-1:0]    wp_r, wp_nxt;    // Write pointer.
    logic [AW-1:0]    rp_r, rp_nxt;    // Read pointer.
    logic [AW:0]      cnt_r, cnt_nxt;  // Occupancy.
    logic             rdy_r, rdy_nxt;  // Room for one more word.
    logic             push;            // Word accepted.
    logic             pop;             // Word handed out.

    // Ready is a flop of its own, computed from the next count, so the framer
    // sees a registered signal. The count is one bit wider than the pointers,
    // so a full buffer never aliases to an empty one.
    assign in_ready  = rdy_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointer and count values.
    always_comb begin
        wp_nxt  = push ? wp_r + AW'(1) : wp_r;
        rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    // Pointer registers and storage write.
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// Line encoder and decoder between framing unit and modem.
module rble_encoder
    import rble_pkg::*;
#(
    parameter int SCR_N = rble_pkg::SCR_LEN,
    parameter int SCR_T = rble_pkg::SCR_TAP
) (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Encoding control register.
    input  wire logic                        ctrl_wr,
    input  wire logic [rble_pkg::CTRL_W-1:0] ctrl_wdata,
    output logic [rble_pkg::CTRL_W-1:0]      ctrl_rdata,
    // Transmit bits from the framer.
    input  wire logic                        tx_bit,
    input  wire logic                        tx_bit_valid,
    output logic                             tx_bit_ready,
    // Transmit symbols to the modulator.
    output logic                             mod_sym,
    output logic                             mod_sym_valid,
    input  wire logic                        mod_sym_ready,
    // Receive symbols from the demodulator.
    input  wire logic                        dem_sym,
    input  wire logic                        dem_sym_valid,
    // Receive bits to the framer.
    output logic                             rx_bit,
    output logic                             rx_bit_valid,
    output logic                             rx_manch_err
);
    import rble_pkg::*;

    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;   // Encoding control register.
    logic              inv, dif, man, shp; // Decoded options.

    // Transmit state.
    logic [SCR_N-1:0]  tscr_r, tscr_nxt;   // Scrambler history.
    logic              tlvl_r, tlvl_nxt;   // Differential level.
    logic              half_r, half_nxt;   // Second half symbol pending.
    logic              sym_r, sym_nxt;     // Symbol on the line.
    logic              symv_r, symv_nxt;   // Symbol valid.
    logic              fo_valid, fo_bit, fo_pop;
    logic              slot;               // Output slot free.
    logic              ts, td, tv;         // Transmit chain taps.

    // Receive state.
    logic [SCR_N-1:0]  rscr_r, rscr_nxt;   // Descrambler history.
    logic              rprev_r, rprev_nxt; // Previous line level.
    logic              rph_r, rph_nxt;     // Waiting for second half.
    logic              rfirst_r, rfirst_nxt;
    logic              rbit_r, rbit_nxt;
    logic              rbv_r, rbv_nxt;
    logic              rerr_r, rerr_nxt;
    logic              have, rv, rl, rd, rs; // Receive chain taps.

    assign inv = ctrl_r[CTRL_INV_BIT];
    assign dif = ctrl_r[CTRL_DIFF_BIT];
    assign man = ctrl_r[CTRL_MANCH_BIT];
    assign shp = ctrl_r[CTRL_SHAPE_BIT];

    // The framer's bits are buffered so a stalled modulator pushes back on it.
    rble_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) rble_fifo_inst (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (tx_bit_valid),
        .in_ready  (tx_bit_ready),
        .in_data   (tx_bit),
        .out_valid (fo_valid),
        .out_ready (fo_pop),
        .out_data  (fo_bit)
    );

    // Control register next value; one write sets all options at once.
    always_comb begin
        ctrl_nxt = ctrl_wr ? ctrl_wdata : ctrl_r;
    end

    // Transmit chain: scramble, differential, invert, then Manchester.
    always_comb begin
        slot     = !symv_r || mod_sym_ready;
        fo_pop   = slot && !half_r && fo_valid;
        // Scrambled bit feeds back into history, so no bit is added.
        ts       = shp ? (fo_bit ^ tscr_r[SCR_N-1] ^ tscr_r[SCR_T-1]) : fo_bit;
        td       = dif ? (tlvl_r ^ ts) : ts;
        tv       = td ^ inv;
        tscr_nxt = tscr_r;
        tlvl_nxt = tlvl_r;
        half_nxt = half_r;
        sym_nxt  = sym_r;
        symv_nxt = symv_r && !mod_sym_ready;
        if (slot && half_r) begin
            // Second half is the complement, giving a mid-bit transition.
            sym_nxt  = !sym_r;
            symv_nxt = 1'b1;
            half_nxt = 1'b0;
        end else if (fo_pop) begin
            tscr_nxt = {tscr_r[SCR_N-2:0], ts};
            tlvl_nxt = td;
            sym_nxt  = tv;
            symv_nxt = 1'b1;
            half_nxt = man;
        end
    end

    // Receive chain: Manchester, invert, differential, then descramble.
    always_comb begin
        rfirst_nxt = rfirst_r;
        rph_nxt    = rph_r;
        rerr_nxt   = 1'b0;
        have       = 1'b0;
        rv         = dem_sym;
        if (dem_sym_valid) begin
            if (!man) begin
                have = 1'b1;
            end else if (!rph_r) begin
                rfirst_nxt = dem_sym;
                rph_nxt    = 1'b1;
            end else begin
                // A pair without a transition is flagged but still decoded.
                rv       = rfirst_r;
                rerr_nxt = (dem_sym == rfirst_r);
                have     = 1'b1;
                rph_nxt  = 1'b0;
            end
        end
        rl       = rv ^ inv;
        rd       = dif ? (rl ^ rprev_r) : rl;
        rs       = shp ? (rd ^ rscr_r[SCR_N-1] ^ rscr_r[SCR_T-1]) : rd;
        rprev_nxt = have ? rl : rprev_r;
        rscr_nxt  = have ? {rscr_r[SCR_N-2:0], rd} : rscr_r;
        rbit_nxt  = have ? rs : rbit_r;
        rbv_nxt   = have;
    end

    // All state registers; reset clears every option and history.
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r   <= CTRL_RESET;
            tscr_r   <= '0;
            tlvl_r   <= 1'b0;
            half_r   <= 1'b0;
            sym_r    <= 1'b0;
            symv_r   <= 1'b0;
            rscr_r   <= '0;
            rprev_r  <= 1'b0;
            rph_r    <= 1'b0;
            rfirst_r <= 1'b0;
            rbit_r   <= 1'b0;
            rbv_r    <= 1'b0;
            rerr_r   <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            tscr_r   <= tscr_nxt;
            tlvl_r   <= tlvl_nxt;
            half_r   <= half_nxt;
            sym_r    <= sym_nxt;
            symv_r   <= symv_nxt;
            rscr_r   <= rscr_nxt;
            rprev_r  <= rprev_nxt;
            rph_r    <= rph_nxt;
            rfirst_r <= rfirst_nxt;
            rbit_r   <= rbit_nxt;
            rbv_r    <= rbv_nxt;
            rerr_r   <= rerr_nxt;
        end
    end

    // Outputs come straight from flops.
    assign ctrl_rdata    = ctrl_r;
    assign mod_sym       = sym_r;
    assign mod_sym_valid = symv_r;
    assign rx_bit        = rbit_r;
    assign rx_bit_valid  = rbv_r;
    assign rx_manch_err  = rerr_r;
endmodule

// ---- sim/rble_chk.sv ----
`timescale 1ns/1ns
// Port checks for the line encoder; reset aborts every attempt in flight.
module rble_chk (
    // Clock, reset and control register.
    input wire logic                        clk,
    input wire logic                        srst,
    input wire logic                        ctrl_wr,
    input wire logic [rble_pkg::CTRL_W-1:0] ctrl_wdata,
    input wire logic [rble_pkg::CTRL_W-1:0] ctrl_rdata,
    // Line symbols and decoded bits.
    input wire logic                        mod_sym,
    input wire logic                        mod_sym_valid,
    input wire logic                        mod_sym_ready,
    input wire logic                        dem_sym,
    input wire logic                        dem_sym_valid,
    input wire logic                        rx_bit,
    input wire logic                        rx_bit_valid
);
    import rble_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Pair phases and first half; they only hold while options stay fixed mid-stream.
    logic tph_r, tph_nxt, half_r, half_nxt, rph_r, rph_nxt;
    always_comb begin
        {tph_nxt, half_nxt, rph_nxt} = {tph_r, half_r, rph_r};
        if (mod_sym_valid && mod_sym_ready && ctrl_rdata[CTRL_MANCH_BIT]) begin
            {tph_nxt, half_nxt} = {!tph_r, mod_sym};
        end
        if (dem_sym_valid && ctrl_rdata[CTRL_MANCH_BIT]) rph_nxt = !rph_r;
        if (srst) {tph_nxt, rph_nxt} = 2'h0;
    end
    // Registers the pair state.
    always_ff @(posedge clk) {tph_r, half_r, rph_r} <= {tph_nxt, half_nxt, rph_nxt};
    chk_ctrl_load: assert property (ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata))
        else $error("control write lost");
    chk_reset_off: assert property ($fell(srst) |-> ctrl_rdata == CTRL_RESET
        && !mod_sym_valid && !rx_bit_valid) else $error("reset state wrong");
    chk_sym_hold: assert property (mod_sym_valid && !mod_sym_ready
        |=> mod_sym_valid && $stable(mod_sym)) else $error("symbol not held");
    chk_rx_pass: assert property (dem_sym_valid && ctrl_rdata == 4'h0
        |=> rx_bit_valid && rx_bit == $past(dem_sym)) else $error("pass-through wrong");
    chk_rx_invert: assert property (dem_sym_valid && ctrl_rdata == 4'h1
        |=> rx_bit_valid && rx_bit != $past(dem_sym)) else $error("inversion wrong");
    chk_rx_cause: assert property (rx_bit_valid |-> $past(dem_sym_valid))
        else $error("bit without symbol");
    chk_manch_half: assert property (mod_sym_valid && ctrl_rdata[CTRL_MANCH_BIT]
        && tph_r |-> mod_sym != half_r) else $error("half without transition");
    chk_rx_pairs: assert property (dem_sym_valid && ctrl_rdata[CTRL_MANCH_BIT]
        && !rph_r |=> !rx_bit_valid) else $error("bit on first half");
endmodule
bind rble_encoder rble_chk rble_chk_inst (.clk(clk), .srst(srst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .mod_sym(mod_sym),
    .mod_sym_valid(mod_sym_valid), .mod_sym_ready(mod_sym_ready), .dem_sym(dem_sym),
    .dem_sym_valid(dem_sym_valid), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));

// ---- sim/rble_mod_model.sv ----
`timescale 1ns/1ns
// Modulator side: takes symbols, stalls every third cycle so the encoder must hold them.
module rble_mod_model (
    // Clock and symbol stream.
    input wire logic clk,
    input wire logic mod_sym,
    input wire logic mod_sym_valid,
    output logic     mod_sym_ready,
    // Full stall request from the bench.
    input wire logic stall
);
    logic       got[$];      // Symbols taken, oldest first.
    logic [1:0] cnt_r = 2'h0; // Stall pattern counter.
    always_ff @(posedge clk) begin
        cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        if (mod_sym_valid && mod_sym_ready) got.push_back(mod_sym);
    end
    assign mod_sym_ready = !stall && cnt_r != 2'h2;
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
// Sends a pattern through each option, then feeds the line symbols back to receive.
module testbench;
    import rble_pkg::*;
    localparam logic [23:0] PAT = 24'h80_0F35;
    logic [CTRL_W-1:0] modes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    logic [CTRL_W-1:0] ctrl_wdata = 4'h0, ctrl_rdata;
    logic              clk = 1'b0, srst = 1'b1, ctrl_wr = 1'b0, tx_bit = 1'b0;
    logic              tx_bit_valid = 1'b0, dem_sym = 1'b0, dem_sym_valid = 1'b0, stall = 1'b0;
    logic              full_seen, tx_bit_ready, mod_sym, mod_sym_valid, mod_sym_ready;
    logic              rx_bit, rx_bit_valid, rx_manch_err, exp_q[$];
    int                n_mismatch = 0, checks_done = 0;
    initial forever #25 clk = !clk;
    rble_encoder rble_encoder_inst (.clk(clk), .srst(srst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .mod_sym(mod_sym),
        .mod_sym_valid(mod_sym_valid), .mod_sym_ready(mod_sym_ready), .dem_sym(dem_sym),
        .dem_sym_valid(dem_sym_valid), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
        .rx_manch_err(rx_manch_err));
    rble_mod_model rble_mod_model_inst (.clk(clk), .mod_sym(mod_sym),
        .mod_sym_valid(mod_sym_valid), .mod_sym_ready(mod_sym_ready), .stall(stall));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One cycle of a bounded wait; running out is a failure.
    task automatic tick(inout int w);
        @(posedge clk) #1;
        w++;
        if (w > 400) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    // Resets the encoder, then writes the option word at the first legal edge.
    task automatic setup(input logic [CTRL_W-1:0] mode);
        @(posedge clk) #1 srst = 1'b1;
        rble_mod_model_inst.got.delete();
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        check("ctrl_rdata", 8'(ctrl_rdata), 8'(CTRL_RESET));
        {ctrl_wr, ctrl_wdata} = {1'b1, mode};
        @(posedge clk) #1 ctrl_wr = 1'b0;
        check("ctrl_rdata", 8'(ctrl_rdata), 8'(mode));
    endtask
    // Pushes the pattern and builds the expected symbols in transmit order.
    task automatic send(input logic [CTRL_W-1:0] mode);
        logic [16:0] h = 17'h0_0000;
        logic l = 1'b0;
        logic s;
        int w = 0;
        exp_q.delete();
        full_seen = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            s = mode[CTRL_SHAPE_BIT] ? PAT[i] ^ h[16] ^ h[11] : PAT[i];
            h = {h[15:0], s};
            l = mode[CTRL_DIFF_BIT] ? l ^ s : s;
            exp_q.push_back(l ^ mode[CTRL_INV_BIT]);
            if (mode[CTRL_MANCH_BIT]) exp_q.push_back(!(l ^ mode[CTRL_INV_BIT]));
            {tx_bit, tx_bit_valid} = {PAT[i], 1'b1};
            while (tx_bit_ready !== 1'b1) begin
                full_seen = 1'b1;
                if (w == 30) stall = 1'b0;
                tick(w);
            end
            @(posedge clk) #1;
        end
        {tx_bit_valid, stall} = 2'h0;
    endtask
    // Waits for all symbols, then compares them in order.
    task automatic drain();
        int w = 0;
        while (rble_mod_model_inst.got.size() < exp_q.size()) tick(w);
        check("symbol count", 8'(rble_mod_model_inst.got.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) check("mod_sym", 8'(rble_mod_model_inst.got[i]), 8'(exp_q[i]));
    endtask
    // Feeds the symbols back, true or inverted, skipping leading bits that may differ.
    task automatic loop_back(input logic flip, input int skip);
        int k = 23;
        foreach (exp_q[i]) begin
            {dem_sym, dem_sym_valid} = {exp_q[i] ^ flip, 1'b1};
            @(posedge clk) #1;
            if (rx_bit_valid === 1'b1) begin
                if (k < 24 - skip) check("rx_bit", 8'(rx_bit), 8'(PAT[k]));
                k--;
            end
        end
        dem_sym_valid = 1'b0;
        check("rx count", 8'(23 - k), 8'h18);
    endtask
    initial begin
        foreach (modes[m]) begin
            setup(modes[m]);
            stall = (m == 0);
            send(modes[m]);
            if (m == 0) check("tx full", 8'(full_seen), 8'h01);
            drain();
            loop_back(1'b0, 0);
            $display("Test of option word %h done", modes[m]);
        end
        setup(4'h2);
        send(4'h2);
        drain();
        loop_back(1'b1, 1);
        $display("Test of inverted differential stream done");
        // A pair without a transition is flagged and still yields its first half.
        setup(4'h4);
        {dem_sym, dem_sym_valid} = 2'h3;
        repeat (2) @(posedge clk) #1;
        check("rx_bit_valid", 8'(rx_bit_valid), 8'h01);
        check("rx_manch_err", 8'(rx_manch_err), 8'h01);
        check("rx_bit", 8'(rx_bit), 8'h01);
        dem_sym = 1'b0;
        @(posedge clk) #1 dem_sym = 1'b1;
        @(posedge clk) #1 dem_sym_valid = 1'b0;
        check("rx_manch_err", 8'(rx_manch_err), 8'h00);
        check("rx_bit", 8'(rx_bit), 8'h00);
        $display("Test of Manchester error flag done");
        print_verdict();
    end
endmodule
